// File: verilog/scc_strap_capture.v
// Our own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`include "scc_defines.vh"
module scc_strap_capture #(
  parameter STRAP_W = `SCC_STRAP_W,
  parameter [2:0] FUSED_CLK_SET = 3'h0
) (
  // clock and reset
  input  wire               clk_sys_in,
  input  wire               rstn_in,
  // expansion address pins
  input  wire [STRAP_W-1:0] exp_addr_in,
  output reg  [STRAP_W-1:0] exp_addr_out,
  output wire [STRAP_W-1:0] exp_addr_oe_out,
  // bus address from the expansion controller
  input  wire [STRAP_W-1:0] bus_addr_in,
  // expansion read data sampling
  input  wire               exp_rd_start_in,
  output reg                exp_rd_sample_out,
  // system address decode
  input  wire [31:0]        sys_addr_in,
  output reg  [1:0]         sys_target_out,
  output reg  [23:0]        sys_offset_out,
  output wire [31:0]        boot_vector_out,
  // configuration outputs
  output wire               mem_map_boot_out,
  output wire [2:0]         core_clk_set_out,
  output wire [3:0]         user_field_out,
  output wire               pci_clk_66_out,
  output wire               pci_arbiter_enable_out,
  output wire               pci_host_out,
  output wire               flash_8bit_out,
  output wire               strap_done_out,
  // register port
  input  wire [`SCC_ADDR_W-1:0] reg_addr_in,
  input  wire [31:0]        reg_wdata_in,
  input  wire               reg_wr_in,
  input  wire               reg_rd_in,
  output reg  [31:0]        reg_rdata_out
);

  reg  [1:0]         state_ff;
  reg  [1:0]         nxt_state;
  reg                load_straps;
  wire [STRAP_W-1:0] strap_q;
  reg                memmap_ff;
  reg  [STRAP_W-1:0] soft_ff;
  reg                soft_valid_ff;
  reg                rd_wait_ff;
  reg                rd_pend_ff;
  reg  [31:0]        config_val;
  wire [2:0]         clk_req;
  wire [3:0]         sys_region;

  // sequencer: reset -> run; straps load in the reset state (first cycle after release), the capture state is never entered
  always @* begin
    nxt_state   = state_ff;
    load_straps = 1'b0;
    case (state_ff)
      `SCC_ST_RESET: begin
        load_straps = 1'b1;
        nxt_state   = `SCC_ST_RUN;
      end
      `SCC_ST_CAPTURE: begin
        nxt_state = `SCC_ST_RUN;
      end
      `SCC_ST_RUN: begin
        nxt_state = `SCC_ST_RUN;
      end
      default: begin
        nxt_state = `SCC_ST_RESET;
      end
    endcase
  end

  always @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      state_ff <= `SCC_ST_RESET;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // pins are inputs during reset and the capture cycle, outputs after
  assign exp_addr_oe_out = (state_ff == `SCC_ST_RUN) ? {STRAP_W{1'b1}}
                                                     : {STRAP_W{1'b0}};
  assign strap_done_out  = (state_ff == `SCC_ST_RUN);

  always @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      exp_addr_out <= {STRAP_W{1'b0}};
    end else begin
      exp_addr_out <= bus_addr_in;
    end
  end

  // pull-up behaviour lives on the pad; the flops reset to 1 so no capture still reads 1
  scc_sync_flop #(
    .WIDTH (STRAP_W)
  ) u_straps (
    .clk_sys_in (clk_sys_in),
    .rstn_in    (rstn_in),
    .load_in    (load_straps),
    .d_in       (exp_addr_in),
    .q_out      (strap_q)
  );

  // software overlay of the low 24 bits; straps stay the source until written
  always @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      memmap_ff     <= 1'b1;
      soft_ff       <= {STRAP_W{1'b1}};
      soft_valid_ff <= 1'b0;
      rd_wait_ff    <= 1'b0;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        `SCC_OFS_CONFIG: begin
          memmap_ff     <= reg_wdata_in[`SCC_BIT_MEMMAP];
          soft_ff       <= reg_wdata_in[STRAP_W-1:0];
          soft_valid_ff <= 1'b1;
        end
        `SCC_OFS_TIMING: begin
          rd_wait_ff <= reg_wdata_in[`SCC_BIT_RDWAIT];
        end
        default: begin
          rd_wait_ff <= rd_wait_ff;
        end
      endcase
    end
  end

  always @* begin
    config_val = 32'h00000000;
    config_val[`SCC_BIT_MEMMAP] = memmap_ff;
    config_val[STRAP_W-1:0]     = soft_valid_ff ? soft_ff : strap_q;
    // reserved bit 3 is kept at 1 whatever software writes
    config_val[`SCC_BIT_RSVD3]  = 1'b1;
  end

  // a larger code is a slower clock; take the slower of request and fuse
  assign clk_req          = config_val[`SCC_CLK_HI:`SCC_CLK_LO];
  assign core_clk_set_out = (clk_req > FUSED_CLK_SET) ? clk_req : FUSED_CLK_SET;
  assign user_field_out   = config_val[`SCC_USER_HI:`SCC_USER_LO];
  assign pci_clk_66_out   = config_val[`SCC_BIT_PCI_CLK];
  assign pci_arbiter_enable_out = config_val[`SCC_BIT_PCI_ARBITER_ENABLE];
  assign pci_host_out     = config_val[`SCC_BIT_PCI_HOST];
  assign flash_8bit_out   = config_val[`SCC_BIT_FLASH8];
  assign mem_map_boot_out = memmap_ff;
  assign boot_vector_out  = `SCC_BOOT_VECTOR;
  assign sys_region       = sys_addr_in[`SCC_REGION_HI:`SCC_REGION_LO];

  // system address decode, registered
  always @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      sys_target_out <= `SCC_TGT_NONE;
      sys_offset_out <= 24'h000000;
    end else begin
      sys_offset_out <= sys_addr_in[`SCC_OFFSET_HI:0];
      if (sys_region == `SCC_REGION_LOW) begin
        if (memmap_ff) begin
          // boot window: flash region decodes only up to 16 mbyte
          sys_target_out <= (sys_addr_in[`SCC_WINDOW_HI:`SCC_WINDOW_LO] == `SCC_WINDOW_BASE)
                            ? `SCC_TGT_EXP : `SCC_TGT_NONE;
        end else begin
          sys_target_out <= `SCC_TGT_SDRAM;
        end
      end else if (sys_region == `SCC_REGION_EXP && !memmap_ff) begin
        // whole region goes to the controller; the 24 pins alias every 16 mbyte
        sys_target_out <= `SCC_TGT_EXP;
      end else begin
        sys_target_out <= `SCC_TGT_NONE;
      end
    end
  end

  // read data sampling: one extra cycle when the slow-edge wait is set
  always @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      rd_pend_ff        <= 1'b0;
      exp_rd_sample_out <= 1'b0;
    end else begin
      rd_pend_ff        <= exp_rd_start_in & rd_wait_ff;
      exp_rd_sample_out <= (exp_rd_start_in & ~rd_wait_ff) | rd_pend_ff;
    end
  end

  // register reads, data one cycle after the strobe
  always @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      reg_rdata_out <= 32'h00000000;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        `SCC_OFS_CONFIG: reg_rdata_out <= config_val;
        `SCC_OFS_TIMING: reg_rdata_out <= {31'h00000000, rd_wait_ff};
        `SCC_OFS_DECODE: reg_rdata_out <= {30'h00000000, strap_done_out, memmap_ff};
        `SCC_OFS_FUSED:  reg_rdata_out <= {29'h00000000, core_clk_set_out};
        default:         reg_rdata_out <= 32'h00000000;
      endcase
    end else begin
      reg_rdata_out <= 32'h00000000;
    end
  end

endmodule

// File: verilog/scc_defines.vh
`ifndef SCC_DEFINES_VH
`define SCC_DEFINES_VH

// register offsets on the plain register port
`define SCC_ADDR_W          4
`define SCC_OFS_CONFIG      4'h0
`define SCC_OFS_TIMING      4'h1
`define SCC_OFS_DECODE      4'h2
`define SCC_OFS_FUSED       4'h3

// configuration register fields
`define SCC_STRAP_W         24
`define SCC_BIT_MEMMAP      31
`define SCC_CLK_HI          23
`define SCC_CLK_LO          21
`define SCC_USER_HI         20
`define SCC_USER_LO         17
`define SCC_BIT_PCI_CLK     4
`define SCC_BIT_RSVD3       3
`define SCC_BIT_PCI_ARBITER_ENABLE     2
`define SCC_BIT_PCI_HOST    1
`define SCC_BIT_FLASH8      0

// reset values
`define SCC_CONFIG_RST      32'h80ffffff
`define SCC_TIMING_RST      32'h00000000

// memory map, in units of 256 Mbyte regions (address bits 31:28)
`define SCC_REGION_LOW      4'h0
`define SCC_REGION_EXP      4'h5
`define SCC_FLASH_TOP       24'hffffff
`define SCC_BOOT_VECTOR     32'h00000000

// system address fields seen by the decode
`define SCC_REGION_HI       31
`define SCC_REGION_LO       28
`define SCC_WINDOW_HI       27
`define SCC_WINDOW_LO       24
`define SCC_WINDOW_BASE     4'h0
`define SCC_OFFSET_HI       23

// timing register fields
`define SCC_BIT_RDWAIT      0

// decode targets
`define SCC_TGT_NONE        2'h0
`define SCC_TGT_SDRAM       2'h1
`define SCC_TGT_EXP         2'h2

// strap capture sequencer states
`define SCC_ST_RESET        2'h0
`define SCC_ST_CAPTURE      2'h1
`define SCC_ST_RUN          2'h2

`endif

// File: verilog/scc_sync_flop.v
`timescale 1ns/1ps
// per-bit capture flops for the strap levels
module scc_sync_flop #(
  parameter WIDTH = 24
) (
  // clock and reset
  input  wire             clk_sys_in,
  input  wire             rstn_in,
  // capture
  input  wire             load_in,
  input  wire [WIDTH-1:0] d_in,
  output wire [WIDTH-1:0] q_out
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg bit_ff;
      // reset value 1 mirrors an unstrapped pin held by its pull-up
      always @(posedge clk_sys_in) begin
        if (!rstn_in) begin
          bit_ff <= 1'b1;
        end else if (load_in) begin
          bit_ff <= d_in[i];
        end
      end
      assign q_out[i] = bit_ff;
    end
  endgenerate

endmodule

// File: tb/scc_board_straps.sv
`timescale 1ns/1ps
// board side of the expansion address pins: weak pull-ups, pull-downs per mask
module scc_board_straps (
  // strap population and device drive
  input  wire logic [23:0] pull_dn_in,
  input  wire logic [23:0] drive_in,
  input  wire logic [23:0] oe_in,
  // resolved pin levels
  output wire logic [23:0] level_out
);
  // a driven pin wins over the resistors; line 3 is never populated with a pull-down
  assign level_out = (oe_in & drive_in) | (~oe_in & ~(pull_dn_in & 24'hfffff7));
endmodule

// File: tb/scc_strap_capture_checker.sv
`timescale 1ns/1ps
`include "scc_defines.vh"
module scc_strap_capture_checker #(
  parameter [2:0] FUSED_CLK_SET = 3'h0
) (
  input wire logic                    clk_sys_in,
  input wire logic                    rstn_in,
  input wire logic [23:0]             exp_addr_in,
  input wire logic [23:0]             exp_addr_oe_out,
  input wire logic                    exp_rd_start_in,
  input wire logic                    exp_rd_sample_out,
  input wire logic [31:0]             sys_addr_in,
  input wire logic [1:0]              sys_target_out,
  input wire logic                    mem_map_boot_out,
  input wire logic [2:0]              core_clk_set_out,
  input wire logic [3:0]              user_field_out,
  input wire logic                    pci_clk_66_out,
  input wire logic                    pci_arbiter_enable_out,
  input wire logic                    pci_host_out,
  input wire logic                    flash_8bit_out,
  input wire logic [`SCC_ADDR_W-1:0]  reg_addr_in,
  input wire logic                    reg_rd_in,
  input wire logic [31:0]             reg_rdata_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  logic [23:0] pins_ff;
  always @(posedge clk_sys_in) begin
    pins_ff <= exp_addr_in;
  end
  sequence s_release;
    !rstn_in ##1 rstn_in ##1 rstn_in;
  endsequence
  sequence s_capture_edge;
    !rstn_in ##1 rstn_in;
  endsequence
  sequence s_turnaround;
    exp_addr_oe_out == 24'h0 ##1 exp_addr_oe_out == 24'hffffff;
  endsequence
  property p_oe_rst;
    !rstn_in |=> exp_addr_oe_out == 24'h0;
  endproperty
  a_oe_rst: assert property (p_oe_rst) else $error("pins driven in reset");
  property p_turn;
    s_capture_edge |-> s_turnaround;
  endproperty
  a_turn: assert property (p_turn) else $error("pin turnaround late");
  property p_capture;
    s_release |-> {user_field_out, pci_clk_66_out, pci_arbiter_enable_out, pci_host_out,
      flash_8bit_out} == {pins_ff[20:17], pins_ff[4], pins_ff[2:0]};
  endproperty
  a_capture: assert property (p_capture) else $error("strap fields");
  property p_clk;
    s_release |-> core_clk_set_out ==
      ((pins_ff[23:21] > FUSED_CLK_SET) ? pins_ff[23:21] : FUSED_CLK_SET);
  endproperty
  a_clk: assert property (p_clk) else $error("clock override");
  property p_boot_bit;
    !rstn_in |=> mem_map_boot_out;
  endproperty
  a_boot_bit: assert property (p_boot_bit) else $error("map bit not set");
  property p_boot_dec;
    disable iff (!rstn_in) (mem_map_boot_out && sys_addr_in[31:24] == 8'h00) ##1
      mem_map_boot_out |-> sys_target_out == `SCC_TGT_EXP;
  endproperty
  a_boot_dec: assert property (p_boot_dec) else $error("boot decode");
  property p_norm_dec;
    disable iff (!rstn_in) (!mem_map_boot_out && sys_addr_in[31:28] == 4'h0) ##1
      !mem_map_boot_out |-> sys_target_out == `SCC_TGT_SDRAM;
  endproperty
  a_norm_dec: assert property (p_norm_dec) else $error("normal decode");
  property p_rd_wait;
    disable iff (!rstn_in) exp_rd_start_in |-> ##[1:2] exp_rd_sample_out;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read sample missing");
  property p_cfg_read;
    disable iff (!rstn_in) reg_rd_in && reg_addr_in == `SCC_OFS_CONFIG |=>
      reg_rdata_out[31] == mem_map_boot_out && reg_rdata_out[20:17] == user_field_out;
  endproperty
  a_cfg_read: assert property (p_cfg_read) else $error("config readback");
endmodule
bind scc_strap_capture scc_strap_capture_checker #(.FUSED_CLK_SET(FUSED_CLK_SET)) i_chk (.*);

// File: tb/test_scc_strap_capture.sv
`timescale 1ns/1ps
`include "scc_defines.vh"
`define CHK(g, e, m) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
  $display("wrong value at %0t: %s", $time, m); end end
module test_scc_strap_capture;
  logic        clk_sys_in = 1'b0;
  logic        rstn_in = 1'b0;
  logic [23:0] pull_dn = 24'h0;
  logic [23:0] bus_addr = 24'h5ac311;
  logic [23:0] pins, drv, oe;
  logic [31:0] sys_addr = 32'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata, bvec;
  logic [3:0]  addr = 4'h0;
  logic [3:0]  user;
  logic [2:0]  core;
  logic [1:0]  tgt;
  logic [23:0] offs;
  logic        rd_start = 1'b0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        rd_sample, map, p66, arb, host, f8, done;
  int          miscompares = 0;
  int          n_compared = 0;
  always #12.5 clk_sys_in = ~clk_sys_in;
  scc_board_straps i_scc_board_straps (.pull_dn_in(pull_dn), .drive_in(drv), .oe_in(oe),
    .level_out(pins));
  scc_strap_capture #(.FUSED_CLK_SET(3'h2)) i_scc_strap_capture (
    .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .exp_addr_in(pins), .exp_addr_out(drv),
    .exp_addr_oe_out(oe), .bus_addr_in(bus_addr), .exp_rd_start_in(rd_start),
    .exp_rd_sample_out(rd_sample), .sys_addr_in(sys_addr), .sys_target_out(tgt),
    .sys_offset_out(offs), .boot_vector_out(bvec), .mem_map_boot_out(map),
    .core_clk_set_out(core), .user_field_out(user), .pci_clk_66_out(p66),
    .pci_arbiter_enable_out(arb), .pci_host_out(host), .flash_8bit_out(f8),
    .strap_done_out(done), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_rdata_out(rdata));
  task automatic tally_and_finish;
    $display("compared %0d, wrong %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // every request starts on a rising edge, never on the check offset
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys_in);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a, input logic [31:0] e, input string m);
    @(posedge clk_sys_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys_in);
    rd <= 1'b0;
    #1 `CHK(rdata, e, m)
  endtask
  task automatic decode(input logic [31:0] a, input logic [1:0] e);
    @(posedge clk_sys_in);
    sys_addr <= a;
    @(posedge clk_sys_in);
    #1 `CHK(tgt, e, "decode target")
    `CHK(offs, a[23:0], "decode offset")
  endtask
  task automatic t_straps(input logic [23:0] pd);
    logic [23:0] cap;
    logic [2:0]  slow;
    cap = ~pd | 24'h000008;
    slow = (cap[23:21] > 3'h2) ? cap[23:21] : 3'h2;
    @(posedge clk_sys_in);
    pull_dn <= pd;
    rstn_in <= 1'b0;
    repeat (6) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    #1 `CHK(oe, 24'hffffff, "pins not driven")
    `CHK({user, p66, arb, host, f8}, {cap[20:17], cap[4], cap[2:0]}, "fields")
    `CHK(core, slow, "clock set")
    `CHK({map, done, bvec}, {2'b11, 32'h0}, "boot state")
    @(posedge clk_sys_in);
    #1 `CHK(drv, bus_addr, "pin drive")
    reg_rd(`SCC_OFS_CONFIG, {8'h80, cap}, "config read");
    reg_rd(`SCC_OFS_DECODE, 32'h00000003, "status read");
    reg_rd(`SCC_OFS_FUSED, {29'h0, slow}, "fused read");
  endtask
  task automatic t_memmap;
    decode(32'h00000100, `SCC_TGT_EXP);
    decode(32'h00fffffc, `SCC_TGT_EXP);
    decode(32'h01000000, `SCC_TGT_NONE);
    decode(32'h50000010, `SCC_TGT_NONE);
    reg_wr(`SCC_OFS_CONFIG, 32'h00ffffff);
    decode(32'h00000100, `SCC_TGT_SDRAM);
    decode(32'h0ffffffc, `SCC_TGT_SDRAM);
    decode(32'h50000010, `SCC_TGT_EXP);
    decode(32'h5ffffffc, `SCC_TGT_EXP);
    reg_rd(`SCC_OFS_CONFIG, 32'h00ffffff, "config after write");
  endtask
  task automatic t_rdwait(input logic w);
    reg_wr(`SCC_OFS_TIMING, {31'h0, w});
    rd_start <= 1'b1;
    @(posedge clk_sys_in);
    rd_start <= 1'b0;
    #1 `CHK(rd_sample, ~w, "early sample")
    @(posedge clk_sys_in);
    #1 `CHK(rd_sample, w, "late sample")
    reg_rd(`SCC_OFS_TIMING, {31'h0, w}, "timing read");
  endtask
  initial begin
    #20000;
    miscompares++;
    tally_and_finish;
  end
  initial begin
    t_straps(24'h000000);
    t_memmap;
    t_straps(24'hfffff7);
    t_rdwait(1'b0);
    t_rdwait(1'b1);
    reg_rd(4'hf, 32'h0, "unmapped read");
    tally_and_finish;
  end
endmodule
